// ==== include/mdc_consts.svh ====
// constants of the motor driver serial port
`ifndef MDC_CONSTS_SVH
`define MDC_CONSTS_SVH
`define MDC_CLK_MHZ 125
`define MDC_CLR_MIN_US 20
`define MDC_CLR_MAX_US 40
`define MDC_OFF_MAX_US 120
`define MDC_WAKE_US 100
`define MDC_FRAME_BITS 11'h010
`define MDC_ZERO_BIT 15
`define MDC_RW_BIT 14
`define MDC_ADDR_HI 13
`define MDC_ADDR_LO 9
`define MDC_STAT_TOP 2'h3
`define MDC_HDR_TOP 2'h2
`define MDC_HDR_CLR_BIT 5
`define MDC_REG_RESET 8'h00
`endif

// ==== include/mdc_pkg.sv ====
// types of the motor driver serial port
package mdc_pkg;
  typedef enum logic [2:0] {
    MDC_CH_STAT,
    MDC_CH_HEADER_BYTE_TWO,
    MDC_CH_ADDR,
    MDC_CH_DATA,
    MDC_CH_DONE,
    MDC_CH_BAD
  } mdc_chain_t;
endpackage : mdc_pkg

// ==== logic/mdc_spi.sv ====
// motor driver serial port with daisy chain, sleep pulse and write fifo
`timescale 1ns/1ns
`default_nettype none
`include "mdc_consts.svh"

module mdc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 4
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr;
  logic [PW-1:0] rd_ptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;
  assign in_ready = count != FULL;
  assign out_valid = count != '0;
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= PW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= PW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= CW'(count + 1'b1);
      end else if (pop && !push) begin
        count <= CW'(count - 1'b1);
      end
    end
  end
endmodule : mdc_fifo

// What this block does
// - active only when awake, enabled, supply good
// - sleep low 20 to 40 us clears faults
// - sleep low 40 to 120 us also clears
// - sleep pulse clears port faults and pulses fault_clear, like the clear bit
// - input frame: zero, rw, address, ignored, data
// - output frame: 11, six flags, register byte
// - write returns register value before the write
// - read returns current register value
// - deselected: ignore clock, output released
// - sample on falling, launch on rising
// - most significant bit first everywhere
// - wrong bit count: error, word discarded
// - chain returns status, headers, then reports
// - header clear bit clears faults at deselect
// - six-bit chain length, at most 63
// - status byte starts 11 then flags
// - position from status count, own bytes latched
// - chained address and data as single frames
// - protocol error latches, pulls fault pin low
// - sleep low for 120 us or more disables serial port
module mdc_spi #(
  parameter int CLR_MAX_CYC = `MDC_CLR_MAX_US * `MDC_CLK_MHZ,
  parameter int OFF_CYC = `MDC_OFF_MAX_US * `MDC_CLK_MHZ,
  parameter int WAKE_CYC = `MDC_WAKE_US * `MDC_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic chip_select_low,
  input wire logic sdi,
  input wire logic sleep_n_pin,
  input wire logic enable_pin,
  input wire logic motor_supply_ok,
  input wire logic chain_mode,
  input wire logic clear_fault_bit,
  input wire logic supply_undervoltage_flag,
  input wire logic pump_undervoltage_flag,
  input wire logic overcurrent_flag,
  input wire logic stall_flag,
  input wire logic thermal_flag,
  input wire logic open_load_flag,
  input wire logic wr_ready,
  output logic sdo,
  output logic sdo_oe,
  output logic active_mode,
  output logic protocol_error,
  output logic fault_out_low,
  output logic fault_clear,
  output logic wr_valid,
  output logic [4:0] wr_addr,
  output logic [7:0] wr_data
);
  localparam int CLR_MIN_CYC = `MDC_CLR_MIN_US * `MDC_CLK_MHZ;

  function automatic logic pick_bit(input logic [7:0] b, input logic [2:0] i);
    pick_bit = b[3'h7 - i];
  endfunction : pick_bit

  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] sdi_q;
  logic [2:0] sleep_q;
  logic [1:0] en_q;
  logic [1:0] vm_q;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sclk_q <= 3'h0;
      cs_q <= 3'h7;
      sdi_q <= 2'h0;
      sleep_q <= 3'h0;
      en_q <= 2'h0;
      vm_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk};
      cs_q <= {cs_q[1:0], chip_select_low};
      sdi_q <= {sdi_q[0], sdi};
      sleep_q <= {sleep_q[1:0], sleep_n_pin};
      en_q <= {en_q[0], enable_pin};
      vm_q <= {vm_q[0], motor_supply_ok};
    end
  end

  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic sleep_rise;
  assign sck_rise = sclk_q[1] && !sclk_q[2];
  assign sck_fall = !sclk_q[1] && sclk_q[2];
  assign cs_fall = !cs_q[1] && cs_q[2];
  assign cs_rise = cs_q[1] && !cs_q[2];
  assign sleep_rise = sleep_q[1] && !sleep_q[2];

  // sleep pin timing, wake delay and mode
  logic [15:0] low_cnt;
  logic [15:0] wake_cnt;
  logic asleep;
  logic slp_clr;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 16'h0000;
      wake_cnt <= 16'h0000;
      asleep <= 1'b1;
      slp_clr <= 1'b0;
      active_mode <= 1'b0;
    end else begin
      slp_clr <= sleep_rise && low_cnt >= 16'(CLR_MIN_CYC) && low_cnt < 16'(OFF_CYC);
      if (!sleep_q[1]) begin
        if (low_cnt != 16'hFFFF) begin
          low_cnt <= 16'(low_cnt + 1'b1);
        end
        if (low_cnt >= 16'(OFF_CYC)) begin
          asleep <= 1'b1;
        end
        wake_cnt <= 16'h0000;
      end else begin
        low_cnt <= 16'h0000;
        if (asleep) begin
          if (wake_cnt >= 16'(WAKE_CYC - 1)) begin
            asleep <= 1'b0;
          end else begin
            wake_cnt <= 16'(wake_cnt + 1'b1);
          end
        end
      end
      active_mode <= !asleep && sleep_q[1] && en_q[1] && vm_q[1];
    end
  end

  // serial frame engine
  logic [7:0] regs [32];
  logic [5:0] flags;
  logic frame;
  logic edge_bad;
  logic [10:0] bitcnt;
  logic [15:0] rx;
  logic [7:0] dly;
  logic [7:0] st;
  logic [7:0] rpt;
  logic [7:0] my_cmd;
  logic [7:0] my_dat;
  logic [5:0] pos;
  logic [5:0] nchain;
  logic [5:0] bidx;
  logic [7:0] dslot;
  logic [7:0] tot;
  logic hdr_clr;
  logic chain_clr;
  logic err_evt;
  mdc_pkg::mdc_chain_t state;
  logic [7:0] nb;
  logic [10:0] j;
  logic [15:0] cmd;
  logic frame_ok;
  logic push;
  logic fifo_ready;
  assign flags = {supply_undervoltage_flag, pump_undervoltage_flag, overcurrent_flag,
                  stall_flag, thermal_flag, open_load_flag};
  assign nb = {rx[6:0], sdi_q[1]};
  assign j = 11'(bitcnt + 1'b1);
  assign cmd = chain_mode ? {my_cmd, my_dat} : rx;
  assign frame_ok = !edge_bad && !sclk_q[1] && !cmd[`MDC_ZERO_BIT] &&
                    (chain_mode ? (state == mdc_pkg::MDC_CH_DONE && bitcnt == {tot, 3'h0})
                                : bitcnt == `MDC_FRAME_BITS);
  assign push = frame && cs_rise && frame_ok && !cmd[`MDC_RW_BIT] && fifo_ready;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      frame <= 1'b0;
      edge_bad <= 1'b0;
      bitcnt <= 11'h000;
      rx <= 16'h0000;
      dly <= 8'h00;
      st <= 8'h00;
      rpt <= 8'h00;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      err_evt <= 1'b0;
      chain_clr <= 1'b0;
    end else begin
      err_evt <= 1'b0;
      chain_clr <= 1'b0;
      if (asleep || (cs_rise && frame)) begin
        frame <= 1'b0;
        sdo_oe <= 1'b0;
        if (!asleep) begin
          err_evt <= !frame_ok || (!cmd[`MDC_RW_BIT] && !fifo_ready);
          chain_clr <= frame_ok && chain_mode && hdr_clr;
        end
      end else if (cs_fall) begin
        frame <= 1'b1;
        edge_bad <= sclk_q[1];
        bitcnt <= 11'h000;
        st <= {`MDC_STAT_TOP, flags};
        sdo <= 1'b1;
        sdo_oe <= 1'b1;
      end else if (frame && sck_fall) begin
        if (bitcnt != 11'h7FF) begin
          bitcnt <= 11'(bitcnt + 1'b1);
        end
        rx <= {rx[14:0], sdi_q[1]};
        dly <= {dly[6:0], sdi_q[1]};
        if (!chain_mode && bitcnt == 11'h006) begin
          rpt <= regs[nb[4:0]];
        end else if (chain_mode && state == mdc_pkg::MDC_CH_ADDR && bitcnt[2:0] == 3'h6 && bidx == pos) begin
          rpt <= regs[nb[4:0]];
        end
      end else if (frame && sck_rise) begin
        if (j < 11'h008) begin
          sdo <= pick_bit(st, j[2:0]);
        end else if (!chain_mode) begin
          sdo <= j < `MDC_FRAME_BITS ? pick_bit(rpt, j[2:0]) : 1'b0;
        end else begin
          sdo <= j[10:3] == dslot ? pick_bit(rpt, j[2:0]) : dly[6];
        end
      end
    end
  end

  // daisy chain byte parser
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= mdc_pkg::MDC_CH_STAT;
      pos <= 6'h00;
      nchain <= 6'h00;
      bidx <= 6'h00;
      dslot <= 8'h00;
      tot <= 8'h00;
      hdr_clr <= 1'b0;
      my_cmd <= 8'h00;
      my_dat <= 8'h00;
    end else if (cs_fall) begin
      state <= mdc_pkg::MDC_CH_STAT;
      pos <= 6'h00;
      bidx <= 6'h00;
      hdr_clr <= 1'b0;
    end else if (frame && sck_fall && bitcnt[2:0] == 3'h7) begin
      unique case (state)
        mdc_pkg::MDC_CH_STAT: begin
          if (nb[7:6] == `MDC_STAT_TOP) begin
            pos <= 6'(pos + 1'b1);
          end else if (nb[7:6] == `MDC_HDR_TOP) begin
            hdr_clr <= nb[`MDC_HDR_CLR_BIT];
            state <= mdc_pkg::MDC_CH_HEADER_BYTE_TWO;
          end else begin
            state <= mdc_pkg::MDC_CH_BAD;
          end
        end
        mdc_pkg::MDC_CH_HEADER_BYTE_TWO: begin
          nchain <= nb[5:0];
          dslot <= 8'({2'h0, pos} + {2'h0, pos} + 8'h03);
          tot <= 8'({2'h0, pos} + {1'h0, nb[5:0], 1'h0} + 8'h02);
          state <= (nb[7:6] != `MDC_HDR_TOP || nb[5:0] == 6'h00 || nb[5:0] <= pos) ?
                   mdc_pkg::MDC_CH_BAD : mdc_pkg::MDC_CH_ADDR;
        end
        mdc_pkg::MDC_CH_ADDR: begin
          if (bidx == pos) begin
            my_cmd <= nb;
          end
          bidx <= bidx == 6'(nchain - 1'b1) ? 6'h00 : 6'(bidx + 1'b1);
          if (bidx == 6'(nchain - 1'b1)) begin
            state <= mdc_pkg::MDC_CH_DATA;
          end
        end
        mdc_pkg::MDC_CH_DATA: begin
          if (bidx == pos) begin
            my_dat <= nb;
          end
          bidx <= 6'(bidx + 1'b1);
          if (bidx == 6'(nchain - 1'b1)) begin
            state <= mdc_pkg::MDC_CH_DONE;
          end
        end
        mdc_pkg::MDC_CH_DONE: begin
          state <= mdc_pkg::MDC_CH_BAD;
        end
        mdc_pkg::MDC_CH_BAD: begin
          state <= mdc_pkg::MDC_CH_BAD;
        end
      endcase
    end
  end

  // fault latch and fault pin
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fault_clear <= 1'b0;
      protocol_error <= 1'b0;
      fault_out_low <= 1'b1;
    end else begin
      fault_clear <= clear_fault_bit || slp_clr || chain_clr;
      if (err_evt) begin
        protocol_error <= 1'b1;
      end else if (fault_clear) begin
        protocol_error <= 1'b0;
      end
      fault_out_low <= !(protocol_error || (|flags));
    end
  end

  // write fifo and register update
  logic f_valid;
  logic [12:0] f_data;
  logic f_pop;
  assign f_pop = f_valid && (!wr_valid || wr_ready);
  mdc_fifo #(.WIDTH(13), .DEPTH(4)) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push),
    .in_data({cmd[`MDC_ADDR_HI:`MDC_ADDR_LO], cmd[7:0]}),
    .in_ready(fifo_ready),
    .out_valid(f_valid),
    .out_data(f_data),
    .out_ready(!wr_valid || wr_ready)
  );
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_valid <= 1'b0;
      wr_addr <= 5'h00;
      wr_data <= 8'h00;
      for (int i = 0; i < 32; i++) begin
        regs[i] <= `MDC_REG_RESET;
      end
    end else begin
      if (f_pop) begin
        wr_valid <= 1'b1;
        wr_addr <= f_data[12:8];
        wr_data <= f_data[7:0];
        regs[f_data[12:8]] <= f_data[7:0];
      end else if (wr_ready) begin
        wr_valid <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence slp_pulse_s;
    sleep_rise && low_cnt >= 16'(CLR_MIN_CYC) && low_cnt < 16'(OFF_CYC);
  endsequence
  sequence clr_out_s;
    ##2 fault_clear;
  endsequence

  idle_release_a: assert property (cs_q[1] && cs_q[2] |-> !sdo_oe)
    else $error("output driven while deselected");
  bad_len_a: assert property (frame && cs_rise && !chain_mode && bitcnt != `MDC_FRAME_BITS |-> ##2 protocol_error)
    else $error("short or long frame not flagged");
  bad_drop_a: assert property (frame && cs_rise && !chain_mode && bitcnt != `MDC_FRAME_BITS |-> !push)
    else $error("bad frame reached the fifo");
  status_top_a: assert property (cs_fall && !asleep && !(cs_rise && frame) |=> st[7:6] == 2'h3 && sdo && sdo_oe)
    else $error("status byte top bits wrong");
  sleep_clear_a: assert property (slp_pulse_s |-> clr_out_s)
    else $error("sleep pulse did not clear faults");
  active_cause_a: assert property (active_mode |-> $past(sleep_q[1]) && $past(en_q[1]) && $past(vm_q[1]))
    else $error("active without enable conditions");
  fault_pin_a: assert property (protocol_error |=> !fault_out_low)
    else $error("fault pin high during protocol error");
  wake_delay_a: assert property ($fell(asleep) |-> $past(wake_cnt) == 16'(WAKE_CYC - 1))
    else $error("woke before wake delay");
  sleep_port_a: assert property (asleep |=> !frame && !sdo_oe)
    else $error("serial port alive in sleep");
endmodule : mdc_spi
`default_nettype wire

// ==== testbench/mdc_host.sv ====
// host side model that frames serial transfers
`timescale 1ns/1ns
`default_nettype none

module mdc_host (
  input wire logic core_clk,
  output var logic sclk,
  output var logic chip_select_low,
  output var logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe
);
  initial begin
    sclk = 1'b0;
    chip_select_low = 1'b1;
    sdi = 1'b0;
  end

  // data line toggles while deselected, clock stands low
  always @(posedge core_clk) begin
    if (chip_select_low) begin
      sdi <= ~sdi;
    end
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick

  // n bits of tx sent msb first, sdo taken before each rising clock
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = 32'h0;
    @(posedge core_clk);
    chip_select_low <= 1'b0;
    tick(10);
    for (int i = n - 1; i >= 0; i--) begin
      rx = {rx[30:0], sdo};
      sclk <= 1'b1;
      sdi <= tx[i];
      tick(10);
      sclk <= 1'b0;
      tick(10);
    end
    chip_select_low <= 1'b1;
    tick(70);
  endtask : xfer
endmodule : mdc_host

`default_nettype wire

// ==== testbench/tb_top.sv ====
// self-checking bench of the motor driver serial port
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic core_clk, rst, sclk, chip_select_low, sdi, sleep_n_pin, enable_pin, motor_supply_ok;
  logic chain_mode, clear_fault_bit, wr_ready, sdo, sdo_oe, active_mode, protocol_error;
  logic fault_out_low, fault_clear, wr_valid;
  logic [5:0] flags;
  logic [4:0] wr_addr, last_wa;
  logic [7:0] wr_data, last_wd;
  logic [31:0] rx;
  int num_errors = 0, checks = 0, nwr = 0, nclr = 0, base;

  mdc_spi #(.OFF_CYC(5000), .WAKE_CYC(50)) i_dut (
    .core_clk(core_clk), .rst(rst), .sclk(sclk), .chip_select_low(chip_select_low),
    .sdi(sdi), .sleep_n_pin(sleep_n_pin), .enable_pin(enable_pin),
    .motor_supply_ok(motor_supply_ok), .chain_mode(chain_mode), .clear_fault_bit(clear_fault_bit),
    .supply_undervoltage_flag(flags[5]), .pump_undervoltage_flag(flags[4]),
    .overcurrent_flag(flags[3]), .stall_flag(flags[2]), .thermal_flag(flags[1]),
    .open_load_flag(flags[0]), .wr_ready(wr_ready), .sdo(sdo), .sdo_oe(sdo_oe),
    .active_mode(active_mode), .protocol_error(protocol_error), .fault_out_low(fault_out_low),
    .fault_clear(fault_clear), .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data)
  );

  mdc_host i_host (
    .core_clk(core_clk), .sclk(sclk), .chip_select_low(chip_select_low),
    .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (wr_valid && wr_ready) begin
      nwr <= nwr + 1;
      last_wa <= wr_addr;
      last_wd <= wr_data;
    end
    if (fault_clear) begin
      nclr <= nclr + 1;
    end
  end

  function automatic logic [15:0] cmd(input logic rw, input logic [4:0] a, input logic [7:0] d);
    return {1'b0, rw, a, 1'b0, d};
  endfunction : cmd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic pulse_clear();
    clear_fault_bit <= 1'b1;
    @(posedge core_clk);
    clear_fault_bit <= 1'b0;
    i_host.tick(6);
  endtask : pulse_clear

  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    $display("BAD t=%0t got=%h exp=%h", $time, 0, 1);
    results();
  end

  initial begin
    rst = 1'b1;
    sleep_n_pin = 1'b1;
    enable_pin = 1'b1;
    motor_supply_ok = 1'b1;
    chain_mode = 1'b0;
    clear_fault_bit = 1'b0;
    wr_ready = 1'b1;
    flags = 6'h00;
    i_host.tick(10);
    check(active_mode, 1'b0);
    check(sdo_oe, 1'b0);
    rst <= 1'b0;
    i_host.tick(80);
    check(active_mode, 1'b1);
    for (int k = 0; k < 2; k++) begin
      if (k == 0) begin
        enable_pin <= 1'b0;
      end else begin
        motor_supply_ok <= 1'b0;
      end
      i_host.tick(8);
      check(active_mode, 1'b0);
      enable_pin <= 1'b1;
      motor_supply_ok <= 1'b1;
      i_host.tick(8);
    end
    $display("test wake done");

    flags <= 6'h25;
    i_host.xfer(16, cmd(1'b0, 5'h0A, 8'h5A), rx);
    check(rx[15:0], 16'hE500);
    flags <= 6'h00;
    check(sdo_oe, 1'b0);
    check({nwr[7:0], 3'h0, last_wa, last_wd}, 32'h010A5A);
    flags <= 6'h1A;
    i_host.xfer(16, cmd(1'b1, 5'h0A, 8'hFF), rx);
    check(rx[15:0], 16'hDA5A);
    check(fault_out_low, 1'b0);
    flags <= 6'h00;
    i_host.xfer(16, cmd(1'b0, 5'h0A, 8'hC3), rx);
    check(rx[15:0], 16'hC05A);
    $display("test single frames done");

    for (int k = 0; k < 2; k++) begin
      base = nwr;
      i_host.xfer(15 + 2 * k, {15'h0, cmd(1'b0, 5'h0A, 8'h00), 1'b0}, rx);
      check({protocol_error, fault_out_low}, 2'b10);
      check(nwr, base);
      if (k == 0) begin
        pulse_clear();
      end else begin
        base = nclr;
        sleep_n_pin <= 1'b0;
        i_host.tick(3000);
        sleep_n_pin <= 1'b1;
        i_host.tick(12);
        check(nclr, base + 1);
      end
      check(protocol_error, 1'b0);
    end
    i_host.xfer(16, cmd(1'b1, 5'h0A, 8'h00), rx);
    check(rx[15:0], 16'hC0C3);
    $display("test frame errors done");

    wr_ready <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      i_host.xfer(16, cmd(1'b0, 5'(i + 1), 8'(8'h10 + i)), rx);
    end
    check(protocol_error, 1'b1);
    base = nwr;
    wr_ready <= 1'b1;
    i_host.tick(30);
    check(nwr - base, 5);
    $display("test write queue done");

    chain_mode <= 1'b1;
    base = nwr;
    i_host.xfer(32, {8'hA0, 8'h81, cmd(1'b0, 5'h0A, 8'h11)}, rx);
    check(rx, {8'hC0, 8'hA0, 8'h81, 8'hC3});
    check(protocol_error, 1'b0);
    check({nwr - base, 3'h0, last_wa, last_wd}, 32'h010A11);
    chain_mode <= 1'b0;
    i_host.xfer(16, cmd(1'b1, 5'h0A, 8'h00), rx);
    check(rx[15:0], 16'hC011);
    $display("test chain done");
    results();
  end
endmodule : tb_top

`default_nettype wire
